// File: hw/bfs_defines.vh
// Opcode codes, flag positions and cycle counts for the bit/flag/stack unit
`ifndef BFS_DEFINES_VH
`define BFS_DEFINES_VH
// Operation codes on i_op
`define BFS_OP_NONE 4'h0
`define BFS_OP_PUSH 4'h1
`define BFS_OP_POP 4'h2
`define BFS_OP_IO_SET 4'h3
`define BFS_OP_IO_CLR 4'h4
`define BFS_OP_ROL 4'h5
`define BFS_OP_ROR 4'h6
`define BFS_OP_BST 4'h7
`define BFS_OP_BLD 4'h8
`define BFS_OP_FSET 4'h9
`define BFS_OP_FCLR 4'ha
`define BFS_OP_BREAK 4'hb
// Flag positions in flags_register
`define BFS_F_C 0
`define BFS_F_Z 1
`define BFS_F_N 2
`define BFS_F_V 3
`define BFS_F_S 4
`define BFS_F_H 5
`define BFS_F_T 6
`define BFS_F_I 7
// Index values for the named set/clear forms
`define BFS_IDX_H 3'h5
`define BFS_IDX_S 3'h4
`define BFS_IDX_V 3'h3
// Reset values and cycle counts
`define BFS_FLAGS_RESET 8'h00
`define BFS_SP_RESET 8'hff
`define BFS_CYC_TWO 2'h2
`define BFS_CYC_ONE 2'h1
`endif

// File: hw/bfs_unit.v
// Execution unit for stack, I/O bit, rotate, bit-transfer and flag operations
`include "bfs_defines.vh"
// How it works
// - Push writes the register to the stack in two cycles, flags untouched.
// - Pop loads the register from the stack in two cycles, no flag change.
// - I/O bit set reads, sets one bit, writes back over two cycles.
// - I/O bit clear reads, clears one bit, writes back over two cycles.
// - Rotate left: carry to bit 0, bit 7 to carry, Z C N V, one cycle.
// - Rotate right: carry to bit 7, bit 0 to carry, Z C N V updated.
// - Bit store copies one register bit into the T flag only.
// - Bit load writes T into one register bit, flags unchanged, one cycle.
// - Half-carry set and clear are single-cycle flag writes.
// - Sign flag set and clear take one cycle, no other flag touched.
// - Overflow clear and set each take one cycle.
// - Break only signals the debug unit and changes no flag.
module bfs_unit #(
  parameter STACK_DEPTH = 256
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_reset_n,
  // Operation request
  input wire i_start,
  input wire [3:0] i_op,
  input wire [7:0] i_reg_value,
  input wire [2:0] i_bit_sel,
  input wire [4:0] i_io_addr,
  // I/O register space read data
  input wire [7:0] i_io_rdata,
  // Results
  output wire o_busy,
  output reg o_done,
  output reg o_reg_we,
  output reg [7:0] o_reg_result,
  output reg o_io_we,
  output reg [4:0] o_io_addr,
  output reg [7:0] o_io_wdata,
  output reg o_debug_break,
  output reg [7:0] o_flags_register,
  output reg [7:0] o_stack_ptr
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta;
  reg rst_sync;
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_SECOND = 1'b1;
  reg state;
  reg [3:0] op_hold;
  reg [7:0] val_hold;
  reg [2:0] bit_hold;
  reg [4:0] addr_hold;
  reg [7:0] stack_mem [0:STACK_DEPTH-1];
  wire [7:0] bit_mask;
  wire [7:0] flags;
  wire carry;
  reg [7:0] rot;
  reg rot_c;
  reg [7:0] next_flags;
  assign bit_mask = 8'h01 << bit_hold;
  assign flags = o_flags_register;
  assign carry = flags[`BFS_F_C];
  // Requests are ignored while the second cycle of a two-cycle op runs
  assign o_busy = (state == ST_SECOND);

  // Rotate result and flags
  always @* begin
    rot = 8'h00;
    rot_c = 1'b0;
    next_flags = flags;
    if (i_op == `BFS_OP_ROL) begin
      rot = {i_reg_value[6:0], carry};
      rot_c = i_reg_value[7];
    end else begin
      rot = {carry, i_reg_value[7:1]};
      rot_c = i_reg_value[0];
    end
    // Z C N V from the result; S keeps its value and does not follow N xor V
    next_flags[`BFS_F_C] = rot_c;
    next_flags[`BFS_F_Z] = (rot == 8'h00);
    next_flags[`BFS_F_N] = rot[7];
    next_flags[`BFS_F_V] = rot[7] ^ rot_c;
  end

  // Stack memory has no reset: contents are undefined until pushed
  always @(posedge i_clk_sys) begin
    if (state == ST_SECOND && op_hold == `BFS_OP_PUSH) begin
      stack_mem[o_stack_ptr] <= val_hold;
    end
  end

  always @(posedge i_clk_sys or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      op_hold <= `BFS_OP_NONE;
      val_hold <= 8'h00;
      bit_hold <= 3'h0;
      addr_hold <= 5'h00;
      o_done <= 1'b0;
      o_reg_we <= 1'b0;
      o_reg_result <= 8'h00;
      o_io_we <= 1'b0;
      o_io_addr <= 5'h00;
      o_io_wdata <= 8'h00;
      o_debug_break <= 1'b0;
      o_flags_register <= `BFS_FLAGS_RESET;
      o_stack_ptr <= `BFS_SP_RESET;
    end else begin
      o_done <= 1'b0;
      o_reg_we <= 1'b0;
      o_io_we <= 1'b0;
      o_debug_break <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_io_addr <= i_io_addr;
          if (i_start) begin
            op_hold <= i_op;
            val_hold <= i_reg_value;
            bit_hold <= i_bit_sel;
            addr_hold <= i_io_addr;
            case (i_op)
              `BFS_OP_PUSH, `BFS_OP_POP, `BFS_OP_IO_SET,
              `BFS_OP_IO_CLR: begin
                state <= ST_SECOND;
              end
              `BFS_OP_ROL, `BFS_OP_ROR: begin
                o_reg_result <= rot;
                o_reg_we <= 1'b1;
                o_flags_register <= next_flags;
                o_done <= 1'b1;
              end
              `BFS_OP_BST: begin
                o_flags_register[`BFS_F_T] <= i_reg_value[i_bit_sel];
                o_done <= 1'b1;
              end
              `BFS_OP_BLD: begin
                o_reg_result <= (i_reg_value & ~(8'h01 << i_bit_sel)) |
                  ({7'h00, flags[`BFS_F_T]} << i_bit_sel);
                o_reg_we <= 1'b1;
                o_done <= 1'b1;
              end
              // The named H, S and V forms are these with a fixed index
              `BFS_OP_FSET: begin
                o_flags_register[i_bit_sel] <= 1'b1;
                o_done <= 1'b1;
              end
              `BFS_OP_FCLR: begin
                o_flags_register[i_bit_sel] <= 1'b0;
                o_done <= 1'b1;
              end
              `BFS_OP_BREAK: begin
                o_debug_break <= 1'b1;
              end
              default: begin
                o_done <= 1'b1;
              end
            endcase
          end
        end
        ST_SECOND: begin
          state <= ST_IDLE;
          o_done <= 1'b1;
          case (op_hold)
            `BFS_OP_PUSH: begin
              o_stack_ptr <= o_stack_ptr - 8'h01;
            end
            `BFS_OP_POP: begin
              o_reg_result <= stack_mem[o_stack_ptr + 8'h01];
              o_reg_we <= 1'b1;
              o_stack_ptr <= o_stack_ptr + 8'h01;
            end
            `BFS_OP_IO_SET: begin
              o_io_wdata <= i_io_rdata | bit_mask;
              o_io_addr <= addr_hold;
              o_io_we <= 1'b1;
            end
            `BFS_OP_IO_CLR: begin
              o_io_wdata <= i_io_rdata & ~bit_mask;
              o_io_addr <= addr_hold;
              o_io_we <= 1'b1;
            end
            default: begin
              o_done <= 1'b1;
            end
          endcase
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// File: verif/bfs_chk.sv
// Assertion checker for the bit/flag/stack unit
`include "bfs_defines.vh"
module bfs_chk (
  input wire i_clk_sys, input wire i_reset_n, input wire i_start,
  input wire [3:0] i_op, input wire [7:0] i_reg_value,
  input wire [2:0] i_bit_sel, input wire [7:0] i_io_rdata,
  input wire o_busy, input wire o_done, input wire o_reg_we,
  input wire [7:0] o_reg_result, input wire o_io_we,
  input wire [7:0] o_io_wdata, input wire o_debug_break,
  input wire [7:0] o_flags_register, input wire [7:0] o_stack_ptr
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  wire go = i_start && !o_busy;
  wire [7:0] f = o_flags_register;
  wire [7:0] sp = o_stack_ptr;
  // ---------------------------------------------
  // Two-cycle ops: busy first, then done
  // ---------------------------------------------
  sequence s_two;
    o_busy ##1 o_done;
  endsequence
  a_push_two: assert property (go && i_op == `BFS_OP_PUSH |=>
    s_two ##0 sp == $past(sp, 2) - 8'h01 && $stable(f)) else $error("push");
  a_pop_two: assert property (go && i_op == `BFS_OP_POP |=>
    s_two ##0 o_reg_we && sp == $past(sp, 2) + 8'h01) else $error("pop");
  a_io_set: assert property (go && i_op == `BFS_OP_IO_SET |=>
    s_two ##0 o_io_we && o_io_wdata == ($past(i_io_rdata) |
    8'h01 << $past(i_bit_sel, 2))) else $error("io set");
  a_io_clear: assert property (go && i_op == `BFS_OP_IO_CLR |=>
    s_two ##0 o_io_we && o_io_wdata == ($past(i_io_rdata) &
    ~(8'h01 << $past(i_bit_sel, 2))) && $stable(f)) else $error("io clr");
  a_rol_carry: assert property (go && i_op == `BFS_OP_ROL |=>
    o_reg_result == {$past(i_reg_value[6:0]), $past(f[0])} &&
    f[0] == $past(i_reg_value[7]) && f[3] == (f[2] ^ f[0]))
    else $error("rol");
  a_ror_carry: assert property (go && i_op == `BFS_OP_ROR |=>
    o_reg_result == {$past(f[0]), $past(i_reg_value[7:1])} &&
    f[0] == $past(i_reg_value[0])) else $error("ror");
  a_bit_store: assert property (go && i_op == `BFS_OP_BST |=>
    f == {$past(f[7]), $past(i_reg_value[i_bit_sel]), $past(f[5:0])})
    else $error("bst");
  a_bit_load: assert property (go && i_op == `BFS_OP_BLD |=>
    o_reg_result[$past(i_bit_sel)] == $past(f[6]) && $stable(f))
    else $error("bld");
  a_flag_set: assert property (go && i_op == `BFS_OP_FSET |=>
    f == ($past(f) | 8'h01 << $past(i_bit_sel))) else $error("fset");
  a_flag_clr: assert property (go && i_op == `BFS_OP_FCLR |=>
    f == ($past(f) & ~(8'h01 << $past(i_bit_sel)))) else $error("fclr");
  a_break_quiet: assert property (go && i_op == `BFS_OP_BREAK |=>
    o_debug_break && !o_done && $stable(f)) else $error("break");
endmodule
bind bfs_unit bfs_chk u_chk (.*);

// File: verif/testbench.sv
// Self-checking testbench for the bit/flag/stack unit
`include "bfs_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  reg i_clk_sys = 1'b0, i_reset_n = 1'b0, i_start = 1'b0;
  reg [3:0] i_op = 4'h0;
  reg [7:0] i_reg_value = 8'h00, i_io_rdata = 8'h12;
  reg [2:0] i_bit_sel = 3'h0;
  reg [4:0] i_io_addr = 5'h1a;
  wire o_busy, o_done, o_reg_we, o_io_we, o_debug_break;
  wire [4:0] o_io_addr;
  wire [7:0] o_reg_result, o_io_wdata, o_flags_register, o_stack_ptr;
  integer n_mismatch = 0, checks = 0, cyc = 0, i;
  reg [7:0] e;
  bfs_unit dut (.*);
  initial forever #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Start stays high so ops run back to back; ends where results stand
  task run(input [3:0] op, input [7:0] v, input [2:0] b);
    i_op = op;
    i_reg_value = v;
    i_bit_sel = b;
    i_start = 1'b1;
    @(posedge i_clk_sys);
    #1;
    if (o_busy) begin
      @(posedge i_clk_sys);
      #1;
    end
  endtask
  initial begin
    repeat (20) @(posedge i_clk_sys);
    #1 i_reset_n = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk(o_flags_register, `BFS_FLAGS_RESET);
    chk(o_stack_ptr, `BFS_SP_RESET);
    run(`BFS_OP_PUSH, 8'ha5, 3'h0);
    chk(o_stack_ptr, 8'hfe);
    chk(o_flags_register, 8'h00);
    run(`BFS_OP_PUSH, 8'h3c, 3'h0);
    run(`BFS_OP_POP, 8'h00, 3'h0);
    chk(o_reg_result, 8'h3c);
    run(`BFS_OP_POP, 8'h00, 3'h0);
    chk(o_reg_result, 8'ha5);
    chk(o_stack_ptr, 8'hff);
    run(`BFS_OP_IO_SET, 8'h00, 3'h7);
    chk(o_io_wdata, 8'h92);
    chk({7'h00, o_io_we}, 8'h01);
    chk({3'h0, o_io_addr}, 8'h1a);
    run(`BFS_OP_IO_CLR, 8'h00, 3'h1);
    chk(o_io_wdata, 8'h10);
    chk({7'h00, o_io_we}, 8'h01);
    e = 8'h00;
    for (i = 0; i < 16; i = i + 1) begin
      e[i % 8] = (i < 8);
      run(i < 8 ? `BFS_OP_FSET : `BFS_OP_FCLR, 8'h00, i[2:0]);
      chk(o_flags_register, e);
    end
    run(`BFS_OP_FSET, 8'h00, 3'h0);
    run(`BFS_OP_ROL, 8'h81, 3'h0);
    chk(o_reg_result, 8'h03);
    chk({6'h00, o_reg_we, o_done}, 8'h03);
    chk(o_flags_register, 8'h09);
    run(`BFS_OP_ROR, 8'h01, 3'h0);
    chk(o_reg_result, 8'h80);
    chk(o_flags_register, 8'h05);
    run(`BFS_OP_BST, 8'h80, 3'h7);
    chk(o_flags_register, 8'h45);
    run(`BFS_OP_BLD, 8'h00, 3'h0);
    chk(o_reg_result, 8'h01);
    run(`BFS_OP_BREAK, 8'h00, 3'h0);
    chk({6'h00, o_debug_break, o_done}, 8'h02);
    chk(o_flags_register, 8'h45);
    i_start = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    print_verdict;
  end
endmodule
